// ==== verilog/rpc_pkg.sv ====
// Constants shared by the receive pattern checker configuration block
package rpc_pkg;
    // ------------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PAT_BYTE2  = 8'h29;
    localparam logic [7:0] ADDR_PAT_BYTE3  = 8'h2A;
    localparam logic [7:0] ADDR_PAT_BYTE4  = 8'h2B;
    localparam logic [7:0] ADDR_PAT_BYTE5  = 8'h2C;
    localparam logic [7:0] ADDR_PAT_BYTE6  = 8'h2D;
    localparam logic [7:0] ADDR_PAT_BYTE7  = 8'h2E;
    localparam logic [7:0] ADDR_THR_FLOAT  = 8'h2F;
    localparam logic [7:0] ADDR_ERR_BYTE0  = 8'h30;
    localparam logic [7:0] ADDR_ERR_BYTE4  = 8'h34;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int         PAT_BYTES       = 6;
    localparam int         PAT_WIDTH       = 64;
    localparam int         ERR_WIDTH       = 40;
    localparam int         MANT_MSB        = 7;
    localparam int         MANT_LSB        = 4;
    localparam int         EXP_MSB         = 3;
    localparam int         EXP_LSB         = 0;
    localparam logic [7:0] PAT_RESET       = 8'hAA;
    localparam logic [7:0] THR_RESET       = 8'hFF;
    localparam logic [1:0] PERIOD_CONT     = 2'h0;
    localparam logic [5:0] BIT_IDX_RESET   = 6'h00;
endpackage

// ==== verilog/rpc_thr_if.sv ====
// Threshold compare carrier between configuration block and comparator
interface rpc_thr_if;
    logic [7:0]  code;
    logic [39:0] count;
    logic        exceeded;

    modport src (output code, output count, input exceeded);
    modport cmp (input code, input count, output exceeded);
endinterface

// ==== verilog/rpc_thr_cmp.sv ====
// Floating-point error threshold comparator
module rpc_thr_cmp (
    rpc_thr_if.cmp thr
);
    import rpc_pkg::*;

    logic [3:0]  mant;
    logic [3:0]  expo;
    logic [67:0] thr_x16;
    logic [67:0] cnt_x16;

    // ------------------------------------------------------------------
    // Compare at sixteen times scale so a fractional threshold is exact
    // ------------------------------------------------------------------
    always_comb begin
        mant    = thr.code[MANT_MSB:MANT_LSB];
        expo    = thr.code[EXP_MSB:EXP_LSB];
        thr_x16 = 68'(mant) << {expo, 2'b00};
        cnt_x16 = {24'h000000, thr.count, 4'h0};
        thr.exceeded = cnt_x16 > thr_x16;
    end
endmodule

// ==== verilog/rpc_cfg.sv ====
// Receive pattern checker configuration, bit compare and threshold flag
module rpc_cfg (
    input  wire logic                  clock_i,
    input  wire logic                  srst_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    output logic      [7:0]            reg_rdata_o,
    input  wire logic [15:0]           pattern_low_i,
    input  wire logic                  rx_bit_i,
    input  wire logic                  rx_bit_valid_i,
    output logic                       bit_err_o,
    output logic                       bit_err_valid_o,
    input  wire logic [1:0]            measure_period_select_i,
    input  wire logic                  period_done_i,
    input  wire logic [rpc_pkg::ERR_WIDTH-1:0] checker_error_total_i,
    input  wire logic                  thresh_irq_ack_i,
    output logic                       thresh_irq_o
);
    import rpc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]           pat_ff [PAT_BYTES];
    logic [7:0]           nxt_pat [PAT_BYTES];
    logic [7:0]           thr_ff;
    logic [7:0]           nxt_thr;
    logic [7:0]           rdata_ff;
    logic [7:0]           nxt_rdata;
    logic [31:0]          hold_ff;
    logic [31:0]          nxt_hold;
    logic [ERR_WIDTH-1:0] last_ff;
    logic [ERR_WIDTH-1:0] nxt_last;
    logic [ERR_WIDTH-1:0] shown;
    logic [5:0]           idx_ff;
    logic [5:0]           nxt_idx;
    logic                 berr_ff;
    logic                 nxt_berr;
    logic                 bval_ff;
    logic                 nxt_bval;
    logic                 irq_ff;
    logic                 nxt_irq;
    logic                 armed_ff;
    logic                 nxt_armed;
    logic [PAT_WIDTH-1:0] full_pat;
    logic                 crossing;

    rpc_thr_if thr_bus ();

    rpc_thr_cmp u_thr_cmp (
        .thr (thr_bus.cmp)
    );

    // ------------------------------------------------------------------
    // Pattern assembly and threshold hookup
    // ------------------------------------------------------------------
    always_comb begin
        full_pat = {pat_ff[5], pat_ff[4], pat_ff[3], pat_ff[2],
                    pat_ff[1], pat_ff[0], pattern_low_i};
        // Absolute count of the running period, no rate scaling
        thr_bus.code  = thr_ff;
        thr_bus.count = checker_error_total_i;
        shown = (measure_period_select_i == PERIOD_CONT) ?
                checker_error_total_i : last_ff;
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always_comb begin
        nxt_pat   = pat_ff;
        nxt_thr   = thr_ff;
        nxt_rdata = rdata_ff;
        nxt_hold  = hold_ff;
        if (reg_wr_i) begin
            if (reg_addr_i == ADDR_PAT_BYTE2) begin
                nxt_pat[0] = reg_wdata_i;
            end else if (reg_addr_i == ADDR_PAT_BYTE3) begin
                nxt_pat[1] = reg_wdata_i;
            end else if (reg_addr_i == ADDR_PAT_BYTE4) begin
                nxt_pat[2] = reg_wdata_i;
            end else if (reg_addr_i == ADDR_PAT_BYTE5) begin
                nxt_pat[3] = reg_wdata_i;
            end else if (reg_addr_i == ADDR_PAT_BYTE6) begin
                nxt_pat[4] = reg_wdata_i;
            end else if (reg_addr_i == ADDR_PAT_BYTE7) begin
                nxt_pat[5] = reg_wdata_i;
            end else if (reg_addr_i == ADDR_THR_FLOAT) begin
                nxt_thr = reg_wdata_i;
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i >= ADDR_PAT_BYTE2 && reg_addr_i <= ADDR_PAT_BYTE7) begin
                nxt_rdata = pat_ff[3'(reg_addr_i - ADDR_PAT_BYTE2)];
            end else if (reg_addr_i == ADDR_THR_FLOAT) begin
                nxt_rdata = thr_ff;
            end else if (reg_addr_i == ADDR_ERR_BYTE0) begin
                // Upper bytes frozen so a multi-byte read cannot tear
                nxt_rdata = shown[7:0];
                nxt_hold  = shown[39:8];
            end else if (reg_addr_i > ADDR_ERR_BYTE0 && reg_addr_i <= ADDR_ERR_BYTE4) begin
                nxt_rdata = hold_ff[{2'(reg_addr_i - ADDR_ERR_BYTE0 - 8'h01), 3'h0} +: 8];
            end else begin
                nxt_rdata = 8'h00;
            end
        end
        if (srst_i) begin
            for (int i = 0; i < PAT_BYTES; i++) begin
                nxt_pat[i] = PAT_RESET;
            end
            nxt_thr   = THR_RESET;
            nxt_rdata = 8'h00;
            nxt_hold  = 32'h00000000;
        end
    end

    always_ff @(posedge clock_i) begin
        pat_ff   <= nxt_pat;
        thr_ff   <= nxt_thr;
        rdata_ff <= nxt_rdata;
        hold_ff  <= nxt_hold;
    end

    // ------------------------------------------------------------------
    // Period snapshot of the error total
    // ------------------------------------------------------------------
    always_comb begin
        nxt_last = last_ff;
        if (period_done_i) begin
            nxt_last = checker_error_total_i;
        end
        if (srst_i) begin
            nxt_last = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        last_ff <= nxt_last;
    end

    // ------------------------------------------------------------------
    // Serial bit compare
    // ------------------------------------------------------------------
    // No alignment search: bit 0 is expected on the first valid after reset
    always_comb begin
        nxt_idx  = idx_ff;
        nxt_berr = berr_ff;
        nxt_bval = rx_bit_valid_i;
        if (rx_bit_valid_i) begin
            nxt_berr = rx_bit_i ^ full_pat[idx_ff];
            nxt_idx  = idx_ff + 6'h01;
        end
        if (srst_i) begin
            nxt_idx  = BIT_IDX_RESET;
            nxt_berr = 1'b0;
            nxt_bval = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        idx_ff  <= nxt_idx;
        berr_ff <= nxt_berr;
        bval_ff <= nxt_bval;
    end

    // ------------------------------------------------------------------
    // Threshold flag
    // ------------------------------------------------------------------
    always_comb begin
        crossing  = thr_bus.exceeded && armed_ff;
        nxt_irq   = irq_ff;
        nxt_armed = armed_ff;
        if (thresh_irq_ack_i) begin
            nxt_irq = 1'b0;
        end
        // Set wins over a same-cycle acknowledge
        if (crossing) begin
            nxt_irq   = 1'b1;
            nxt_armed = 1'b0;
        end else if (period_done_i || !thr_bus.exceeded) begin
            nxt_armed = 1'b1;
        end
        if (srst_i) begin
            nxt_irq   = 1'b0;
            nxt_armed = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        irq_ff   <= nxt_irq;
        armed_ff <= nxt_armed;
    end

    always_comb begin
        reg_rdata_o     = rdata_ff;
        bit_err_o       = berr_ff;
        bit_err_valid_o = bval_ff;
        thresh_irq_o    = irq_ff;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_pat_reset: assert property (@(posedge clock_i)
        srst_i |=> (pat_ff[0] == PAT_RESET && pat_ff[5] == PAT_RESET))
        else $error("pattern byte not at reset value");

    chk_pat_write: assert property (@(posedge clock_i) disable iff (srst_i)
        reg_wr_i && reg_addr_i == ADDR_PAT_BYTE7 |=> full_pat[63:56] == $past(reg_wdata_i))
        else $error("top pattern byte not written");

    chk_thr_reset: assert property (@(posedge clock_i)
        srst_i |=> thr_ff == THR_RESET)
        else $error("threshold not all ones after reset");

    chk_bit_order: assert property (@(posedge clock_i) disable iff (srst_i)
        rx_bit_valid_i && idx_ff == 6'h3F |=> idx_ff == 6'h00)
        else $error("bit index did not wrap after MSB");

    chk_bit_compare: assert property (@(posedge clock_i) disable iff (srst_i)
        rx_bit_valid_i |=> bit_err_valid_o && bit_err_o == ($past(rx_bit_i) ^
        $past(full_pat[idx_ff])))
        else $error("bit compare mismatch");

    chk_irq_set: assert property (@(posedge clock_i) disable iff (srst_i)
        thr_bus.exceeded && armed_ff |=> thresh_irq_o)
        else $error("flag not raised on crossing");

    chk_irq_hold: assert property (@(posedge clock_i) disable iff (srst_i)
        thresh_irq_o && !thresh_irq_ack_i |=> thresh_irq_o)
        else $error("flag dropped without acknowledge");

    chk_irq_once: assert property (@(posedge clock_i) disable iff (srst_i)
        crossing ##1 (thr_bus.exceeded && !period_done_i)[*2] |-> !crossing)
        else $error("second crossing inside one period");

    chk_zero_thr: assert property (@(posedge clock_i) disable iff (srst_i)
        thr_ff == 8'h00 && checker_error_total_i != '0 |-> thr_bus.exceeded)
        else $error("zero threshold not exceeded by nonzero count");

    chk_snap_hold: assert property (@(posedge clock_i) disable iff (srst_i)
        period_done_i ##1 !period_done_i |-> last_ff == $past(checker_error_total_i))
        else $error("period total not captured");

    chk_latch_read: assert property (@(posedge clock_i) disable iff (srst_i)
        reg_rd_i && reg_addr_i == ADDR_ERR_BYTE4 && !reg_wr_i |=>
        reg_rdata_o == $past(hold_ff[31:24]))
        else $error("upper byte not from latched copy");

    chk_thr_write: assert property (@(posedge clock_i) disable iff (srst_i)
        reg_wr_i && reg_addr_i == ADDR_THR_FLOAT |=> thr_ff == $past(reg_wdata_i))
        else $error("threshold byte not written");

    chk_max_thr: assert property (@(posedge clock_i) disable iff (srst_i)
        thr_ff == THR_RESET |-> !thr_bus.exceeded)
        else $error("largest threshold exceeded by a 40-bit count");

    chk_irq_clear: assert property (@(posedge clock_i) disable iff (srst_i)
        thresh_irq_ack_i && !crossing |=> !thresh_irq_o)
        else $error("flag not cleared by acknowledge");

    chk_set_wins: assert property (@(posedge clock_i) disable iff (srst_i)
        crossing && thresh_irq_ack_i |=> thresh_irq_o)
        else $error("acknowledge overrode a new crossing");

    chk_idx_step: assert property (@(posedge clock_i) disable iff (srst_i)
        rx_bit_valid_i |=> idx_ff == $past(idx_ff) + 6'h01)
        else $error("bit index did not advance");

    chk_valid_pulse: assert property (@(posedge clock_i) disable iff (srst_i)
        !rx_bit_valid_i |=> !bit_err_valid_o)
        else $error("result valid without a received bit");

    chk_cont_read: assert property (@(posedge clock_i) disable iff (srst_i)
        reg_rd_i && reg_addr_i == ADDR_ERR_BYTE0 && measure_period_select_i == PERIOD_CONT
        |=> reg_rdata_o == $past(checker_error_total_i[7:0]))
        else $error("continuous read not the running total");

    chk_rdata_hold: assert property (@(posedge clock_i) disable iff (srst_i)
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");

    cov_crossing: cover property (@(posedge clock_i) disable iff (srst_i)
        crossing ##[1:8] thresh_irq_ack_i);
    cov_bit_error: cover property (@(posedge clock_i) disable iff (srst_i)
        bit_err_valid_o && bit_err_o);
    cov_count_read: cover property (@(posedge clock_i) disable iff (srst_i)
        reg_rd_i && reg_addr_i == ADDR_ERR_BYTE0 ##[1:4]
        reg_rd_i && reg_addr_i == ADDR_ERR_BYTE4);
    cov_set_wins: cover property (@(posedge clock_i) disable iff (srst_i)
        crossing && thresh_irq_ack_i);
endmodule

// ==== sim/tb_rx_pattern_checker_cfg.sv ====
// Self-checking bench for the receive pattern checker configuration block
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value at %0t: %s", $time, msg); end end
module tb_rx_pattern_checker_cfg;
    timeunit 1ns;
    timeprecision 1ps;
    import rpc_pkg::*;

    // ---------------------------------------------------------------
    // Stimulus, clock and counters
    // ---------------------------------------------------------------
    logic        clock_i    = 1'b0;
    logic        srst_i     = 1'b1;
    logic        reg_wr_i   = 1'b0;
    logic        reg_rd_i   = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic [7:0]  reg_rdata_o;
    logic [15:0] pattern_low_i = 16'h6C3E;
    logic        rx_bit_i = 1'b0;
    logic        rx_bit_valid_i = 1'b0;
    logic        bit_err_o;
    logic        bit_err_valid_o;
    logic [1:0]  measure_period_select_i = 2'h0;
    logic        period_done_i = 1'b0;
    logic [39:0] checker_error_total_i = 40'h00_0000_0000;
    logic        thresh_irq_ack_i = 1'b0;
    logic        thresh_irq_o;
    logic [47:0] pat_hi = 48'hC3_5A_0F_96_E1_7B;
    logic [63:0] pat;
    logic [7:0]  thr_tab [4] = '{8'h00, 8'h80, 8'h12, 8'h31};
    logic [39:0] lo_tab  [4] = '{40'h0, 40'h0, 40'h10, 40'h3};
    int          miscompares = 0;
    int          checked = 0;
    int          cycles = 0;

    always #2 clock_i = ~clock_i;

    rpc_cfg dut (
        .clock_i                 (clock_i),
        .srst_i                  (srst_i),
        .reg_wr_i                (reg_wr_i),
        .reg_rd_i                (reg_rd_i),
        .reg_addr_i              (reg_addr_i),
        .reg_wdata_i             (reg_wdata_i),
        .reg_rdata_o             (reg_rdata_o),
        .pattern_low_i           (pattern_low_i),
        .rx_bit_i                (rx_bit_i),
        .rx_bit_valid_i          (rx_bit_valid_i),
        .bit_err_o               (bit_err_o),
        .bit_err_valid_o         (bit_err_valid_o),
        .measure_period_select_i (measure_period_select_i),
        .period_done_i           (period_done_i),
        .checker_error_total_i   (checker_error_total_i),
        .thresh_irq_ack_i        (thresh_irq_ack_i),
        .thresh_irq_o            (thresh_irq_o)
    );

    // ---------------------------------------------------------------
    // Bus and closing tasks
    // ---------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // Strobes stay up between calls so back-to-back cycles never glitch
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_rd_i = 1'b0;
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        tick(1);
        `CHK(reg_rdata_o, e, "register read")
    endtask

    task automatic idle();
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        tick(1);
    endtask

    task automatic ack();
        thresh_irq_ack_i = 1'b1;
        tick(1);
        thresh_irq_ack_i = 1'b0;
        tick(2);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_values();
        for (int k = 0; k < PAT_BYTES; k++) rd(ADDR_PAT_BYTE2 + 8'(k), PAT_RESET);
        rd(ADDR_THR_FLOAT, THR_RESET);
        wr(8'h10, 8'h5A);
        rd(8'h10, 8'h00);
        idle();
        checker_error_total_i = 40'hFF_FFFF_FFFF;
        tick(3);
        `CHK(thresh_irq_o, 1'b0, "max threshold never crossed")
        checker_error_total_i = 40'h0;
        tick(2);
    endtask

    task automatic t_reg_rw();
        for (int k = 0; k < PAT_BYTES; k++) wr(ADDR_PAT_BYTE2 + 8'(k), pat_hi[8*k+:8]);
        wr(ADDR_THR_FLOAT, 8'h5C);
        for (int k = 0; k < PAT_BYTES; k++) rd(ADDR_PAT_BYTE2 + 8'(k), pat_hi[8*k+:8]);
        rd(ADDR_THR_FLOAT, 8'h5C);
        idle();
    endtask

    // Bits 37 and 63 flipped: a byte-order or bit-order slip moves the errors
    task automatic t_bit_compare();
        pat = {pat_hi, pattern_low_i};
        for (int i = 0; i <= 64; i++) begin
            if (i > 0) begin
                `CHK(bit_err_valid_o, 1'b1, "bit result valid")
                `CHK(bit_err_o, (i == 38 || i == 64), "bit mismatch flag")
            end
            rx_bit_valid_i = (i < 64);
            rx_bit_i = pat[i%64] ^ (i == 37 || i == 63);
            tick(1);
        end
        `CHK(bit_err_valid_o, 1'b0, "no result without a bit")
    endtask

    // Just at the threshold stays quiet, one above raises, ack holds it down
    task automatic t_threshold();
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_THR_FLOAT, thr_tab[k]);
            idle();
            checker_error_total_i = lo_tab[k];
            tick(3);
            `CHK(thresh_irq_o, 1'b0, "at threshold")
            checker_error_total_i = lo_tab[k] + 40'h1;
            tick(3);
            `CHK(thresh_irq_o, 1'b1, "above threshold")
            ack();
            `CHK(thresh_irq_o, 1'b0, "one raise per crossing")
            checker_error_total_i = 40'h0;
            tick(2);
        end
    endtask

    task automatic t_period();
        measure_period_select_i = 2'h1;
        checker_error_total_i = 40'h12_3456_789A;
        tick(3);
        `CHK(thresh_irq_o, 1'b1, "raised in period")
        ack();
        period_done_i = 1'b1;
        tick(1);
        period_done_i = 1'b0;
        // Crossing and acknowledge in one cycle: the set must win
        checker_error_total_i = 40'h4;
        thresh_irq_ack_i = 1'b1;
        tick(1);
        thresh_irq_ack_i = 1'b0;
        tick(1);
        `CHK(thresh_irq_o, 1'b1, "raised again next period")
        ack();
        rd(ADDR_ERR_BYTE0, 8'h9A);
        idle();
        period_done_i = 1'b1;
        tick(1);
        period_done_i = 1'b0;
        rd(ADDR_ERR_BYTE0 + 8'h1, 8'h78);
        rd(ADDR_ERR_BYTE0 + 8'h2, 8'h56);
        rd(ADDR_ERR_BYTE0 + 8'h3, 8'h34);
        rd(ADDR_ERR_BYTE4, 8'h12);
        rd(ADDR_ERR_BYTE0, 8'h04);
        rd(ADDR_ERR_BYTE4, 8'h00);
        measure_period_select_i = PERIOD_CONT;
        checker_error_total_i = 40'hAB_CDEF_0123;
        rd(ADDR_ERR_BYTE0, 8'h23);
        rd(ADDR_ERR_BYTE4, 8'hAB);
        idle();
    endtask

    // Reset in mid-run must undo writes, the flag and the bit position
    task automatic t_mid_reset();
        rx_bit_valid_i = 1'b1;
        rx_bit_i = 1'b0;
        tick(1);
        rx_bit_valid_i = 1'b0;
        srst_i = 1'b1;
        tick(2);
        srst_i = 1'b0;
        `CHK(thresh_irq_o, 1'b0, "flag cleared by reset")
        `CHK(reg_rdata_o, 8'h00, "read data cleared by reset")
        rd(ADDR_PAT_BYTE7, PAT_RESET);
        rd(ADDR_THR_FLOAT, THR_RESET);
        idle();
        rx_bit_valid_i = 1'b1;
        rx_bit_i = pattern_low_i[0];
        tick(1);
        rx_bit_valid_i = 1'b0;
        `CHK(bit_err_o, 1'b0, "bit index back at zero")
    endtask

    initial begin
        tick(5);
        srst_i = 1'b0;
        `CHK(thresh_irq_o, 1'b0, "flag clear after reset")
        t_reset_values();
        t_reg_rw();
        t_bit_compare();
        t_threshold();
        t_period();
        t_mid_reset();
        end_of_test();
    end
endmodule
